// file: core/io_line_consts.svh
`ifndef IO_LINE_CONSTS_SVH
`define IO_LINE_CONSTS_SVH

`define CLK_MHZ 50
`define TICK_US 1
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)
`define TICK_CNT_W 6

`define REG_IN_TRIG_SEL 8'h00
`define REG_LINE_SEL 8'h04
`define REG_LINE_SOURCE 8'h08
`define REG_LINE_INVERT 8'h0C
`define REG_LINE_STATUS 8'h10
`define REG_LINE_STATUS_ALL 8'h14
`define REG_USER_OUT_SEL 8'h18
`define REG_USER_OUT_VAL 8'h1C
`define REG_USER_OUT_ALL 8'h20
`define REG_TIMER_SEL 8'h24
`define REG_TIMER_TRIG_SRC 8'h28
`define REG_TIMER_DELAY 8'h2C
`define REG_TIMER_DUR 8'h30
`define REG_DELAY_BASE 8'h34
`define REG_DUR_BASE 8'h38

`define TRIG_SEL_RESET 2'h1
`define DELAY_MAX 12'hFFF
`define DUR_MIN 12'h001
`define BASE_RESET 16'h0001
`define RAW_W 12
`define BASE_W 16
`endif

// file: core/io_line_pkg.sv
package io_line_pkg;
    typedef enum logic [1:0] {
        SRC_EXPOSURE = 2'h0,
        SRC_TRIG_READY = 2'h1,
        SRC_TIMER = 2'h2,
        SRC_USER = 2'h3
    } line_source_t;

    typedef enum logic [2:0] {
        TMR_IDLE = 3'b001,
        TMR_DELAY = 3'b010,
        TMR_HIGH = 3'b100
    } timer_state_t;
endpackage : io_line_pkg

// file: core/camera_io_line_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_line_consts.svh"

// Behaviour
// R01: Two synchronised input lines and four output lines, each configurable and readable.
// R02: Reset routes input line 1 to the hardware trigger.
// R03: One trigger selector register, so a new choice releases the old line.
// R04: The trigger line reads as zero in user status.
// R05: User input levels readable per selected line and as a combined word.
// R06: Per output line source: exposure active, trigger ready, timer, or user level.
// R07: Reset drives line 1 from exposure active and line 2 from trigger ready.
// R08: Selected user output set by a boolean and read back.
// R09: Low four bits of a 32-bit word set all user outputs together.
// R10: User level is applied before the inverter.
// R11: Per line inversion enable complements the chosen source.
// R12: Each timer waits delay low, then high for duration, then low.
// R13: Exposure start is the sole timer trigger source.
// R14: Timer N drives only output line N.
// R15: Inversion gives high during delay and low during duration.
// R16: Timer selector picks which timer's settings are written.
// R17: Delay is raw count 0..4095 times the delay time base; a raw count of 0 runs as 1.
// R18: One delay time base shared by all timers, in microsecond steps.
// R19: Duration is raw count 1..4095 times the shared duration time base.
// R20: A one-microsecond tick advances the timer counters.
// R21: Triggers during a running timer are ignored.
// R22: Inputs pass two flip-flop stages before use.
module camera_io_line_control
    import io_line_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [1:0] line_in_i,
    input wire logic exposure_active_i,
    input wire logic trigger_ready_i,
    output logic hw_trigger_input_o,
    output logic [3:0] line_out_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    function automatic logic [1:0] sel_index(input logic [31:0] value);
        sel_index = value[1:0];
    endfunction : sel_index

    // Timer N is wired only to pin N, so the timer level handed in is always the pin's own timer.
    function automatic logic source_level(input line_source_t src, input logic expo, input logic rdy,
        input logic tmr, input logic usr);
        source_level = 1'b0;
        unique case (src)
            SRC_EXPOSURE: source_level = expo;
            SRC_TRIG_READY: source_level = rdy;
            SRC_TIMER: source_level = tmr;
            SRC_USER: source_level = usr;
        endcase
    endfunction : source_level

    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] trig_sel_ff;
    logic [1:0] line_sel_ff;
    logic [1:0] user_sel_ff;
    logic [1:0] timer_sel_ff;
    logic [1:0] line_src_ff [4];
    logic [3:0] invert_ff;
    logic [3:0] user_val_ff;
    logic [3:0] timer_arm_ff;
    logic [`RAW_W-1:0] delay_raw_ff [4];
    logic [`RAW_W-1:0] dur_raw_ff [4];
    logic [`BASE_W-1:0] delay_base_ff;
    logic [`BASE_W-1:0] dur_base_ff;
    logic [`TICK_CNT_W-1:0] tick_cnt_ff;
    logic tick_ff;
    logic exp_dly_ff;
    logic [1:0] user_in;
    logic exp_start;
    logic wr;
    logic rd_req;
    logic [31:0] nxt_rdata;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign exp_start = exposure_active_i && !exp_dly_ff; // R13

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
        end
        else if (ce_i)
        begin
            sync1_ff <= line_in_i; // R22
            sync2_ff <= sync1_ff; // R22
        end
    end

    // Selector value 1 is input line 1 (bit 0), 2 is input line 2; 0 detaches the trigger.
    always_comb
    begin
        hw_trigger_input_o = 1'b0;
        user_in = sync2_ff;
        if (trig_sel_ff == 2'h1)
        begin
            hw_trigger_input_o = sync2_ff[0]; // R03
            user_in[0] = 1'b0; // R04
        end
        else if (trig_sel_ff == 2'h2)
        begin
            hw_trigger_input_o = sync2_ff[1]; // R03
            user_in[1] = 1'b0; // R04
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
            exp_dly_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            exp_dly_ff <= exposure_active_i;
            tick_ff <= 1'b0;
            if (tick_cnt_ff == `TICK_CNT_W'(`TICK_CYCLES - 1))
            begin
                tick_cnt_ff <= '0;
                tick_ff <= 1'b1; // R20
            end
            else
            begin
                tick_cnt_ff <= tick_cnt_ff + `TICK_CNT_W'(1);
            end
        end
    end

    // The 16-bit base prescaler feeds the 12-bit raw counter; a zero delay still takes one delay time base period.
    generate
        for (genvar g = 0; g < 4; g++)
        begin : gen_timer
            timer_state_t state_ff;
            logic [`BASE_W-1:0] base_cnt_ff;
            logic [`RAW_W-1:0] raw_cnt_ff;
            logic base_done;
            logic timer_high;
            logic pin_ff;
            assign base_done = tick_ff && (base_cnt_ff == 16'h0001 || base_cnt_ff == 16'h0000);
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    state_ff <= TMR_IDLE;
                    base_cnt_ff <= '0;
                    raw_cnt_ff <= '0;
                end
                else if (ce_i)
                begin
                    unique case (state_ff)
                        TMR_IDLE:
                        begin
                            if (exp_start && timer_arm_ff[g]) // R21
                            begin
                                state_ff <= TMR_DELAY; // R12
                                base_cnt_ff <= delay_base_ff;
                                raw_cnt_ff <= delay_raw_ff[g];
                            end
                        end
                        TMR_DELAY:
                        begin
                            if (tick_ff)
                            begin
                                base_cnt_ff <= base_done ? delay_base_ff : base_cnt_ff - 16'h0001; // R18
                            end
                            if (base_done && raw_cnt_ff <= 12'h001)
                            begin
                                state_ff <= TMR_HIGH; // R17
                                base_cnt_ff <= dur_base_ff;
                                raw_cnt_ff <= dur_raw_ff[g];
                            end
                            else if (base_done)
                            begin
                                raw_cnt_ff <= raw_cnt_ff - 12'h001;
                            end
                        end
                        TMR_HIGH:
                        begin
                            if (tick_ff)
                            begin
                                base_cnt_ff <= base_done ? dur_base_ff : base_cnt_ff - 16'h0001;
                            end
                            if (base_done && raw_cnt_ff <= 12'h001)
                            begin
                                state_ff <= TMR_IDLE; // R19
                            end
                            else if (base_done)
                            begin
                                raw_cnt_ff <= raw_cnt_ff - 12'h001;
                            end
                        end
                        default:
                        begin
                            state_ff <= TMR_IDLE;
                        end
                    endcase
                end
            end
            assign timer_high = (state_ff == TMR_HIGH); // R12

            // Each pin register lives in its own scope, so every output bit has exactly one driver.
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pin_ff <= 1'b0;
                end
                else if (ce_i)
                begin
                    pin_ff <= source_level(line_source_t'(line_src_ff[g]), exposure_active_i, trigger_ready_i,
                        timer_high, user_val_ff[g]) ^ invert_ff[g]; // R06 R10 R11 R14 R15
                end
            end
        end
    endgenerate

    assign line_out_o = {gen_timer[3].pin_ff, gen_timer[2].pin_ff,
        gen_timer[1].pin_ff, gen_timer[0].pin_ff}; // R01

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            trig_sel_ff <= `TRIG_SEL_RESET; // R02
            line_sel_ff <= '0;
            line_src_ff[0] <= SRC_EXPOSURE; // R07
            line_src_ff[1] <= SRC_TRIG_READY; // R07
            line_src_ff[2] <= SRC_USER;
            line_src_ff[3] <= SRC_USER;
            invert_ff <= '0;
        end
        else if (ce_i && wr)
        begin
            unique case (wb_adr_i)
                `REG_IN_TRIG_SEL: trig_sel_ff <= (wb_dat_i[1:0] == 2'h3) ? trig_sel_ff : wb_dat_i[1:0]; // R03
                `REG_LINE_SEL: line_sel_ff <= sel_index(wb_dat_i);
                `REG_LINE_SOURCE: line_src_ff[line_sel_ff] <= wb_dat_i[1:0]; // R06
                `REG_LINE_INVERT: invert_ff[line_sel_ff] <= wb_dat_i[0]; // R11
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            user_sel_ff <= '0;
            user_val_ff <= '0;
        end
        else if (ce_i && wr)
        begin
            unique case (wb_adr_i)
                `REG_USER_OUT_SEL: user_sel_ff <= sel_index(wb_dat_i);
                `REG_USER_OUT_VAL: user_val_ff[user_sel_ff] <= wb_dat_i[0]; // R08
                `REG_USER_OUT_ALL: user_val_ff <= wb_dat_i[3:0]; // R09
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_sel_ff <= '0;
            timer_arm_ff <= '0;
            for (int i = 0; i < 4; i++)
            begin
                delay_raw_ff[i] <= '0;
                dur_raw_ff[i] <= `DUR_MIN;
            end
        end
        else if (ce_i && wr)
        begin
            unique case (wb_adr_i)
                `REG_TIMER_SEL: timer_sel_ff <= sel_index(wb_dat_i); // R16
                `REG_TIMER_TRIG_SRC: timer_arm_ff[timer_sel_ff] <= wb_dat_i[0]; // R13 R16
                `REG_TIMER_DELAY: delay_raw_ff[timer_sel_ff] <= wb_dat_i[11:0]; // R17
                `REG_TIMER_DUR: dur_raw_ff[timer_sel_ff] <= (wb_dat_i[11:0] == 12'h000) ? `DUR_MIN : wb_dat_i[11:0]; // R19
                default: ;
            endcase
        end
    end

    // Zero time bases are forced to one, so a timer can never stall on an empty prescaler.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            delay_base_ff <= `BASE_RESET;
            dur_base_ff <= `BASE_RESET;
        end
        else if (ce_i && wr)
        begin
            unique case (wb_adr_i)
                `REG_DELAY_BASE: delay_base_ff <= (wb_dat_i[15:0] == 16'h0000) ? `BASE_RESET : wb_dat_i[15:0]; // R18
                `REG_DUR_BASE: dur_base_ff <= (wb_dat_i[15:0] == 16'h0000) ? `BASE_RESET : wb_dat_i[15:0];
                default: ;
            endcase
        end
    end

    // Status reads return the synchronised pins, so a user line lags its pin by two cycles.
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            `REG_IN_TRIG_SEL: nxt_rdata[1:0] = trig_sel_ff;
            `REG_LINE_SEL: nxt_rdata[1:0] = line_sel_ff;
            `REG_LINE_SOURCE: nxt_rdata[1:0] = line_src_ff[line_sel_ff];
            `REG_LINE_INVERT: nxt_rdata[0] = invert_ff[line_sel_ff];
            `REG_LINE_STATUS: nxt_rdata[0] = user_in[line_sel_ff[0]]; // R05
            `REG_LINE_STATUS_ALL: nxt_rdata[5:0] = {line_out_o, user_in}; // R05 R01
            `REG_USER_OUT_SEL: nxt_rdata[1:0] = user_sel_ff;
            `REG_USER_OUT_VAL: nxt_rdata[0] = user_val_ff[user_sel_ff]; // R08
            `REG_USER_OUT_ALL: nxt_rdata[3:0] = user_val_ff; // R09
            `REG_TIMER_SEL: nxt_rdata[1:0] = timer_sel_ff;
            `REG_TIMER_TRIG_SRC: nxt_rdata[0] = timer_arm_ff[timer_sel_ff];
            `REG_TIMER_DELAY: nxt_rdata[11:0] = delay_raw_ff[timer_sel_ff];
            `REG_TIMER_DUR: nxt_rdata[11:0] = dur_raw_ff[timer_sel_ff];
            `REG_DELAY_BASE: nxt_rdata[15:0] = delay_base_ff;
            `REG_DUR_BASE: nxt_rdata[15:0] = dur_base_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= rd_req;
            wb_dat_o <= rd_req ? nxt_rdata : 32'h0000_0000;
        end
    end

endmodule : camera_io_line_control
`default_nettype wire

// file: bench/cam_io_equipment.sv
`timescale 1ns/1ps
`default_nettype none
module cam_io_equipment (
    input wire logic clk_i,
    input wire logic [1:0] lvl_i,
    output var logic [1:0] line_in_o = 2'h0
);
    // A sensor holds its level between edges; it never glitches mid-cycle.
    always @(posedge clk_i)
    begin
        line_in_o <= lvl_i;
    end
endmodule : cam_io_equipment
`default_nettype wire

// file: bench/camera_io_line_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module camera_io_line_control_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] line_in_i,
    input wire logic exposure_active_i,
    input wire logic trigger_ready_i,
    input wire logic hw_trigger_input_o,
    input wire logic [3:0] line_out_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    logic wr_seen_ff;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Reset routing is only checkable until software first writes a setting.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wr_seen_ff <= 1'b0;
        else if (wb_ack_o && wb_we_i)
            wr_seen_ff <= 1'b1;
    end
    ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    user_all_width_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h20
        |-> wb_dat_o[31:4] == 28'h000_0000) else $error("user word upper bits set");
    status_width_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h14
        |-> wb_dat_o[31:6] == 26'h000_0000) else $error("status word upper bits set");
    reset_out_a: assert property ($past(rst_i) |-> line_out_o == 4'h0)
        else $error("outputs not low after reset");
    default_src_a: assert property (!wr_seen_ff && !$past(rst_i) |-> line_out_o ==
        {2'b00, $past(trigger_ready_i), $past(exposure_active_i)}) else $error("default routing");
    sync_stages_a: assert property ($changed(line_in_i) |-> $stable(hw_trigger_input_o)
        ##1 $stable(hw_trigger_input_o)) else $error("input not synchronised");
endmodule : camera_io_line_control_chk
bind camera_io_line_control camera_io_line_control_chk u_chk (.clk_i, .rst_i, .line_in_i,
    .exposure_active_i, .trigger_ready_i, .hw_trigger_input_o, .line_out_o, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

// file: bench/tb_camera_io_line_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_line_consts.svh"
module tb_camera_io_line_control;
    logic clk_i = 1'b0, rst_i = 1'b1, expo = 1'b0, trdy = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hw, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, dato;
    logic [1:0] lvl = 2'h0, line_in;
    logic [3:0] lo, v;
    int fails = 0, compares = 0;
    integer seed = 32'he90c_4b4a;
    logic [63:0] q[$];
    cam_io_equipment ext (.clk_i(clk_i), .lvl_i(lvl), .line_in_o(line_in));
    camera_io_line_control uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .line_in_i(line_in),
        .exposure_active_i(expo), .trigger_ready_i(trdy), .hw_trigger_input_o(hw),
        .line_out_o(lo), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack));
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [11:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {20'h0_0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50)
        begin
            fails++;
            wrap_up;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [11:0] m, input logic [11:0] e);
        q.push_back({20'hF_FFFF, m, 20'h0_0000, e});
        bus(1'b0, a, 12'h000);
    endtask : rd
    task automatic meas(input logic pol, input int dexp, input int hexp);
        int d, h;
        d = 0;
        h = 0;
        check({31'h0, lo[3]}, {31'h0, pol});
        expo <= 1'b1;
        @(posedge clk_i);
        while (lo[3] === pol && d < 2000)
        begin
            @(posedge clk_i);
            d++;
        end
        // A second exposure start while high must not restart the timer.
        while (lo[3] === ~pol && h < 2000)
        begin
            @(posedge clk_i);
            h++;
            expo <= (h < 3 || h > 5);
        end
        expo <= 1'b0;
        check({31'h0, d > dexp - 60 && d < dexp + 60}, 32'h1);
        check({31'h0, h > hexp - 60 && h < hexp + 60}, 32'h1);
    endtask : meas
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
        begin
            check(dato & q[0][63:32], q[0][31:0]);
            void'(q.pop_front());
        end
    end
    initial
    begin
        #(20 * 30000);
        fails++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            {expo, trdy} <= i ? 2'b01 : 2'b10;
            repeat (4) @(posedge clk_i);
            check({28'h000_0000, lo}, i ? 32'h0000_0002 : 32'h0000_0001);
        end
        {expo, trdy, lvl} <= 4'b0001;
        repeat (4) @(posedge clk_i);
        rd(`REG_IN_TRIG_SEL, 12'hFFF, 12'h001);
        check({31'h0, hw}, 32'h1);
        bus(1'b1, `REG_IN_TRIG_SEL, 12'h002);
        bus(1'b1, `REG_IN_TRIG_SEL, 12'h003);
        rd(`REG_IN_TRIG_SEL, 12'hFFF, 12'h002);
        rd(8'h3C, 12'hFFF, 12'h000);
        check({31'h0, hw}, 32'h0);
        $display("test input routing done");
        for (int i = 2; i < 4; i++)
        begin
            bus(1'b1, `REG_LINE_SEL, 12'(i));
            bus(1'b1, `REG_LINE_SOURCE, 12'(io_line_pkg::SRC_USER));
        end
        bus(1'b1, `REG_LINE_SEL, 12'h002);
        for (int i = 0; i < 6; i++)
        begin
            v = 4'($random(seed));
            lvl <= 2'($random(seed));
            bus(1'b1, `REG_USER_OUT_ALL, {8'h00, v});
            repeat (3) @(posedge clk_i);
            check({30'h0, lo[3:2]}, {30'h0, v[3:2]});
            rd(`REG_USER_OUT_ALL, 12'hFFF, {8'h00, v});
            rd(`REG_LINE_STATUS_ALL, 12'h003, {11'h000, lvl[0]});
            rd(`REG_LINE_STATUS, 12'h001, {11'h000, lvl[0]});
        end
        bus(1'b1, `REG_USER_OUT_SEL, 12'h002);
        bus(1'b1, `REG_USER_OUT_VAL, 12'h001);
        rd(`REG_USER_OUT_VAL, 12'h001, 12'h001);
        check({31'h0, lo[2]}, 32'h1);
        bus(1'b1, `REG_LINE_SEL, 12'h002);
        bus(1'b1, `REG_LINE_INVERT, 12'h001);
        repeat (3) @(posedge clk_i);
        check({31'h0, lo[2]}, 32'h0);
        $display("test user outputs done");
        for (int t = 0; t < 4; t++)
        begin
            bus(1'b1, `REG_TIMER_SEL, 12'(t));
            bus(1'b1, `REG_TIMER_TRIG_SRC, 12'h001);
            bus(1'b1, `REG_TIMER_DELAY, 12'h003);
            bus(1'b1, `REG_TIMER_DUR, 12'h002);
        end
        bus(1'b1, `REG_LINE_SEL, 12'h003);
        bus(1'b1, `REG_LINE_SOURCE, 12'(io_line_pkg::SRC_TIMER));
        repeat (3) @(posedge clk_i);
        meas(1'b0, 3 * `TICK_CYCLES, 2 * `TICK_CYCLES);
        bus(1'b1, `REG_LINE_INVERT, 12'h001);
        bus(1'b1, `REG_DELAY_BASE, 12'h002);
        repeat (3) @(posedge clk_i);
        meas(1'b1, 6 * `TICK_CYCLES, 2 * `TICK_CYCLES);
        $display("test timers done");
        wrap_up;
    end
endmodule : tb_camera_io_line_control
`default_nettype wire
